// ---- slrc_map.vh ----
// Index map, field values and timing constants of the local/remote configuration bank
`ifndef SLRC_MAP_VH
`define SLRC_MAP_VH
`define SLRC_IDX_LOCKS 8'h0C
`define SLRC_IDX_OP_SOURCE 8'h41
`define SLRC_IDX_PIN2_FUNC 8'h47
`define SLRC_IDX_PIN2_POL 8'h4C
`define SLRC_IDX_POT_SP 8'h5A
`define SLRC_IDX_PIN2_STATE 8'h5C
`define SLRC_IDX_REMOTE_SP 8'h5B
`define SLRC_OP_REMOTE 8'h00
`define SLRC_OP_LOCAL 8'h01
`define SLRC_PIN2_FUNC_OFF 8'h00
`define SLRC_PIN2_FUNC_ON 8'h10
`define SLRC_POL_HIGH 8'h00
`define SLRC_POL_LOW 8'h01
`define SLRC_PIN2_INACTIVE 8'h00
`define SLRC_PIN2_ACTIVE 8'h01
`define SLRC_PIN2_OPEN 8'h02
`define SLRC_LOCK_LOCAL_BIT 2
`define SLRC_LOCKS_RST 16'h0000
`define SLRC_SP_MIN 32'h000001CC
`define SLRC_SP_MAX 32'h00000FEB
`define SLRC_SP_RST 32'h000001CC
`define SLRC_LINK_HOLD 16'h2000
`define SLRC_CLK_HZ 10000000
`define SLRC_BAUD 38400
`define SLRC_BIT_CYCLES (`SLRC_CLK_HZ / `SLRC_BAUD)
`endif

// ---- slrc_sync.v ----
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module slrc_sync #(
  parameter W = 1
) (
  input wire clk_sys, // System clock
  input wire reset, // Synchronous reset, active high
  input wire [W-1:0] d_in, // Asynchronous input
  output reg [W-1:0] d_out // Synchronised output
);
  reg [W-1:0] meta_r;
  // First stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= {W{1'b0}};
      d_out <= {W{1'b0}};
    end else begin
      meta_r <= d_in;
      d_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- slrc_config.v ----
// Local/remote configuration bank: potentiometer, pin 2 lock and parameter access
`timescale 1ns/1ps
`default_nettype none
`include "slrc_map.vh"
module slrc_config #(
  parameter HAS_POT = 1, // 1 on the potentiometer variant
  parameter [7:0] OP_SOURCE_RST = 8'h00 // Reset source on other variants
) (
  input wire clk_sys, // System clock, 10 MHz
  input wire reset, // Synchronous reset, active high
  input wire [11:0] pot_level, // Potentiometer position, from pin domain
  input wire pin2_level, // Pin 2 raw level
  input wire pin2_open, // Pin 2 floating detect
  input wire [15:0] meas_value, // Measured value from sensing front end
  input wire meas_stable, // Front-end stability flag
  input wire par_wr, // Parameter write strobe from link stack
  input wire par_rd, // Parameter read strobe from link stack
  input wire [7:0] par_index, // Parameter index
  input wire [31:0] par_wdata, // Write data
  input wire link_active, // Link stack reports a frame
  input wire [7:0] nv_op_source, // Stored values loaded after reset
  input wire [7:0] nv_pin2_func, // Stored pin 2 function
  input wire [7:0] nv_pin2_pol, // Stored pin 2 polarity
  input wire [15:0] nv_locks, // Stored access locks
  input wire [31:0] nv_remote_sp, // Stored remote switching point
  input wire nv_valid, // Stored values valid, one-cycle pulse
  output reg [31:0] par_rdata, // Read data
  output reg par_ack, // Read or write answered
  output reg par_err, // Unknown index or read-only write
  output reg nv_save, // Pulse: store current configuration
  output reg [31:0] active_sp, // Switching point in use
  output reg detect_out, // Switching output
  output reg [3:0] led_state, // Indicator: switch, stable, local, link
  output reg teach_active // Potentiometer teach in progress
);
  localparam [7:0] SRC_RST = HAS_POT ? `SLRC_OP_LOCAL : OP_SOURCE_RST;
  reg [7:0] op_source_r;
  reg [7:0] pin2_func_r;
  reg [7:0] pin2_pol_r;
  reg [15:0] locks_r;
  reg [31:0] remote_sp_r;
  reg [31:0] pot_sp_r;
  reg [7:0] pin2_state_r;
  reg [15:0] link_cnt_r;
  reg [11:0] pot_prev_r;
  reg [2:0] warm_r; // Sync pipeline filled after reset
  wire [11:0] pot_s;
  wire pin2_s;
  wire open_s;
  wire pin2_eff;
  wire pin2_locked;
  wire local_lock;
  wire [31:0] pot_clamped;
  wire [31:0] sp_sel;
  wire pot_ok;
  wire sp_hit;

  // Clamp to the declared read-back range; narrower range not enforced
  function [31:0] clamp_sp;
    input [31:0] v;
    begin
      if (v < `SLRC_SP_MIN)
        clamp_sp = `SLRC_SP_MIN;
      else if (v > `SLRC_SP_MAX)
        clamp_sp = `SLRC_SP_MAX;
      else
        clamp_sp = v;
    end
  endfunction

  // Indices that accept writes; everything else is refused
  function rw_index;
    input [7:0] idx;
    begin
      case (idx)
        `SLRC_IDX_OP_SOURCE, `SLRC_IDX_PIN2_FUNC, `SLRC_IDX_PIN2_POL,
        `SLRC_IDX_LOCKS, `SLRC_IDX_REMOTE_SP: rw_index = 1'b1;
        default: rw_index = 1'b0;
      endcase
    end
  endfunction

  // Pin inputs cross into the clock domain
  slrc_sync #(.W(14)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_in({pot_level, pin2_level, pin2_open}),
    .d_out({pot_s, pin2_s, open_s})
  );

  // Effective pin 2 level and lock decision
  assign pin2_eff = (pin2_pol_r == `SLRC_POL_LOW) ? ~pin2_s : pin2_s;
  assign pin2_locked = (pin2_func_r == `SLRC_PIN2_FUNC_ON) && !open_s && !pin2_eff;
  assign local_lock = locks_r[`SLRC_LOCK_LOCAL_BIT];
  assign pot_clamped = clamp_sp({20'h00000, pot_s});
  // Remote mode ignores the potentiometer point; pot_sp_r still tracks the knob
  assign sp_sel = (op_source_r == `SLRC_OP_LOCAL) ? pot_sp_r : remote_sp_r;
  // Knob bits may settle on different edges; take a value seen twice
  assign pot_ok = warm_r[2] && (pot_s == pot_prev_r);
  // Compare against the selection in use
  assign sp_hit = ({16'h0000, meas_value} >= sp_sel);

  // Parameter writes, stored-value load and potentiometer tracking
  always @(posedge clk_sys) begin
    if (reset) begin
      op_source_r <= SRC_RST;
      pin2_func_r <= `SLRC_PIN2_FUNC_ON;
      pin2_pol_r <= `SLRC_POL_HIGH;
      locks_r <= `SLRC_LOCKS_RST;
      remote_sp_r <= `SLRC_SP_RST;
      pot_sp_r <= `SLRC_SP_RST;
      pot_prev_r <= 12'h000;
      warm_r <= 3'h0;
      teach_active <= 1'b0;
      nv_save <= 1'b0;
    end else begin
      nv_save <= 1'b0;
      pot_prev_r <= pot_s;
      // History is trusted only once real pin samples fill it
      warm_r <= {warm_r[1:0], 1'b1};
      // Lock freezes the last accepted switching point, not the knob
      if (!pin2_locked && !local_lock) begin
        if (pot_ok)
          pot_sp_r <= pot_clamped;
        // Warm-up gate stops the reset-to-knob jump from looking like a turn
        teach_active <= (pot_s != pot_prev_r) && warm_r[2] &&
                        (op_source_r == `SLRC_OP_LOCAL);
      end else begin
        teach_active <= 1'b0;
      end
      if (nv_valid) begin
        op_source_r <= nv_op_source;
        pin2_func_r <= nv_pin2_func;
        pin2_pol_r <= nv_pin2_pol;
        locks_r <= nv_locks;
        remote_sp_r <= nv_remote_sp;
      end else if (par_wr) begin
        nv_save <= rw_index(par_index);
        case (par_index)
          `SLRC_IDX_OP_SOURCE: op_source_r <= par_wdata[7:0];
          `SLRC_IDX_PIN2_FUNC: pin2_func_r <= par_wdata[7:0];
          `SLRC_IDX_PIN2_POL: pin2_pol_r <= par_wdata[7:0];
          `SLRC_IDX_LOCKS: locks_r <= par_wdata[15:0];
          `SLRC_IDX_REMOTE_SP: remote_sp_r <= par_wdata;
          default: nv_save <= 1'b0;
        endcase
      end
    end
  end

  // Parameter read-back and answer; one cycle after the strobe
  always @(posedge clk_sys) begin
    if (reset) begin
      par_rdata <= 32'h00000000;
      par_ack <= 1'b0;
      par_err <= 1'b0;
    end else begin
      par_ack <= par_rd | par_wr;
      par_err <= 1'b0;
      if (par_rd) begin
        case (par_index)
          `SLRC_IDX_OP_SOURCE: par_rdata <= {24'h000000, op_source_r};
          `SLRC_IDX_PIN2_FUNC: par_rdata <= {24'h000000, pin2_func_r};
          `SLRC_IDX_PIN2_POL: par_rdata <= {24'h000000, pin2_pol_r};
          `SLRC_IDX_LOCKS: par_rdata <= {16'h0000, locks_r};
          `SLRC_IDX_REMOTE_SP: par_rdata <= remote_sp_r;
          `SLRC_IDX_POT_SP: par_rdata <= pot_sp_r;
          `SLRC_IDX_PIN2_STATE: par_rdata <= {24'h000000, pin2_state_r};
          default: begin
            par_rdata <= 32'h00000000;
            par_err <= 1'b1;
          end
        endcase
      end else if (par_wr) begin
        // Read-only and unknown indices refuse writes
        par_err <= !rw_index(par_index);
      end
    end
  end

  // Pin 2 status, switching and indicator
  always @(posedge clk_sys) begin
    if (reset) begin
      pin2_state_r <= `SLRC_PIN2_ACTIVE;
      active_sp <= `SLRC_SP_RST;
      detect_out <= 1'b0;
      led_state <= 4'h0;
      link_cnt_r <= 16'h0000;
    end else begin
      if (open_s)
        pin2_state_r <= `SLRC_PIN2_OPEN;
      else if (pin2_locked)
        pin2_state_r <= `SLRC_PIN2_INACTIVE;
      else
        pin2_state_r <= `SLRC_PIN2_ACTIVE;
      active_sp <= sp_sel;
      // Lower point means higher sensitivity; knob at min may self-trigger
      detect_out <= sp_hit;
      // Link activity is stretched so a short frame stays visible
      if (link_active)
        link_cnt_r <= `SLRC_LINK_HOLD;
      else if (link_cnt_r != 16'h0000)
        link_cnt_r <= link_cnt_r - 16'h0001;
      led_state <= {link_cnt_r != 16'h0000, op_source_r == `SLRC_OP_LOCAL,
                    meas_stable, sp_hit};
    end
  end
endmodule
`default_nettype wire

// ---- slrc_config_monitor.sv ----
// Assertions on the parameter port of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module slrc_config_monitor (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Sync reset
  input wire logic par_wr, // Write strobe
  input wire logic par_rd, // Read strobe
  input wire logic [7:0] par_index, // Index
  input wire logic [31:0] par_rdata, // Read data
  input wire logic par_ack, // Answer
  input wire logic par_err, // Refusal
  input wire logic nv_save, // Store pulse
  input wire logic detect_out // Switching output
);
  // One domain; checks idle while reset holds
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ack_one_cycle: assert property (par_ack == $past(par_rd || par_wr))
    else $error("answer strobe out of step");
  a_ro_write_refused: assert property (par_wr && par_index inside {8'h5A, 8'h5C}
    |=> par_err && !nv_save) else $error("read-only write accepted");
  a_sp_in_range: assert property (par_rd && par_index == 8'h5A
    |=> par_rdata inside {[32'h1CC:32'hFEB]}) else $error("switching point out of range");
  a_state_codes: assert property (par_rd && par_index == 8'h5C
    |=> par_rdata <= 32'h2) else $error("pin state code unknown");
  a_pol_byte: assert property (par_rd && par_index == 8'h4C
    |=> par_rdata[31:1] == 31'h0) else $error("polarity value illegal");
  a_func_values: assert property (par_rd && par_index == 8'h47
    |=> par_rdata inside {32'h0, 32'h10}) else $error("pin function value illegal");
  a_locks_width: assert property (par_rd && par_index == 8'h0C
    |=> par_rdata[31:16] == 16'h0) else $error("lock record too wide");
  a_write_saved: assert property (par_wr && par_index == 8'h4C
    |=> nv_save && !par_err) else $error("accepted write not stored");
  // Main scenarios reached
  cover property (par_wr && par_index == 8'h4C);
  cover property (par_err);
  cover property (detect_out);
endmodule
bind slrc_config slrc_config_monitor slrc_config_monitor_i (.clk_sys, .reset, .par_wr,
  .par_rd, .par_index, .par_rdata, .par_ack, .par_err, .nv_save, .detect_out);
`default_nettype wire

// ---- slrc_master_model.sv ----
// Link-master model issuing parameter requests
`timescale 1ns/1ps
`default_nettype none
module slrc_master_model (
  input wire logic clk_sys, // Clock
  output logic par_rd = 1'b0, // Read strobe
  output logic par_wr = 1'b0, // Write strobe
  output logic [7:0] par_index = 8'h00, // Index
  output logic [31:0] par_wdata = 32'h00000000, // Write data
  input wire logic [31:0] par_rdata, // Read data
  input wire logic par_err // Refusal
);
  // Sole master of this port; data flipped after use so stale values show
  task xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    #1;
    {par_wr, par_rd, par_index, par_wdata} = {w, !w, i, d};
    @(posedge clk_sys);
    #1;
    {par_wr, par_rd, par_wdata} = {2'b00, ~d};
    q = par_rdata;
    e = par_err;
  endtask
endmodule
`default_nettype wire

// ---- tb_sensor_local_remote_config.sv ----
// Bench for the local/remote configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_local_remote_config;
  typedef struct {logic w; logic [7:0] i; logic [31:0] d, q; logic e;} slrc_row_t;
  logic clk_sys, reset, pin2_level, pin2_open, meas_stable, link_active, nv_valid, e;
  logic [11:0] pot_level;
  logic [15:0] meas_value, nv_locks;
  logic [7:0] nv_op_source, nv_pin2_func, nv_pin2_pol;
  logic [31:0] nv_remote_sp, q;
  wire par_wr, par_rd, par_ack, par_err, nv_save, detect_out, teach_active;
  wire [7:0] par_index;
  wire [31:0] par_wdata, par_rdata, active_sp;
  wire [3:0] led_state;
  int err_total, checks, cyc;
  slrc_row_t rows [9];
  slrc_config slrc_config_i (.clk_sys, .reset, .pot_level, .pin2_level, .pin2_open,
    .meas_value, .meas_stable, .par_wr, .par_rd, .par_index, .par_wdata, .link_active,
    .nv_op_source, .nv_pin2_func, .nv_pin2_pol, .nv_locks, .nv_remote_sp, .nv_valid,
    .par_rdata, .par_ack, .par_err, .nv_save, .active_sp, .detect_out, .led_state,
    .teach_active);
  slrc_master_model slrc_master_model_i (.clk_sys, .par_rd, .par_wr, .par_index,
    .par_wdata, .par_rdata, .par_err);
  task chk(input string n, input logic [31:0] x, s);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
    end
  endtask
  task rchk(input logic [7:0] i, input logic [31:0] x);
    slrc_master_model_i.xfer(1'b0, i, 32'h0, q, e);
    chk("read", x, q);
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    slrc_master_model_i.xfer(1'b1, i, d, q, e);
  endtask
  // Pin inputs need two sync edges plus one; ends off the edge
  task hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task conclude;
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    {reset, pin2_level, pin2_open, meas_stable, link_active, nv_valid} = 6'b110000;
    {pot_level, meas_value, nv_locks} = {12'h800, 32'h0};
    {nv_op_source, nv_pin2_func, nv_pin2_pol, nv_remote_sp} = '0;
    rows = '{'{0, 8'h47, 0, 32'h10, 0}, '{0, 8'h41, 0, 32'h1, 0}, '{0, 8'h00, 0, 0, 1},
      '{1, 8'h5A, 32'h5, 0, 1}, '{1, 8'h5C, 32'h1, 0, 1}, '{1, 8'h4C, 32'h1, 0, 0},
      '{0, 8'h4C, 0, 32'h1, 0}, '{1, 8'h47, 0, 0, 0}, '{0, 8'h47, 0, 0, 0}};
    hold(3);
    reset = 1'b0;
    hold(3);
    chk("teach idle", 32'h0, teach_active);
    foreach (rows[k]) begin
      slrc_master_model_i.xfer(rows[k].w, rows[k].i, rows[k].d, q, e);
      chk("error flag", rows[k].e, e);
      if (!rows[k].w) chk("table read", rows[k].q, q);
    end
    rchk(8'h5C, 32'h1);
    pin2_open = 1'b1;
    hold(4);
    rchk(8'h5C, 32'h2);
    pin2_open = 1'b0;
    wr(8'h47, 32'h10);
    hold(4);
    rchk(8'h5C, 32'h0);
    pot_level = 12'hFFF;
    hold(4);
    rchk(8'h5A, 32'h800);
    pin2_level = 1'b0;
    hold(4);
    rchk(8'h5A, 32'hFEB);
    chk("local point", 32'hFEB, active_sp);
    pot_level = 12'h010;
    hold(3);
    chk("teach", 32'h1, teach_active);
    hold(1);
    rchk(8'h5A, 32'h1CC);
    wr(8'h5B, 32'h600);
    wr(8'h41, 32'h0);
    rchk(8'h41, 32'h0);
    {pot_level, meas_value, meas_stable, link_active} = {12'h900, 16'h0600, 2'b11};
    hold(4);
    chk("remote point", 32'h600, active_sp);
    chk("detect", 32'h1, detect_out);
    chk("indicator", 32'hB, led_state);
    {meas_value, link_active} = {16'h05FF, 1'b0};
    hold(3);
    chk("detect", 32'h0, detect_out);
    chk("link stretch", 32'h1, led_state[3]);
    {nv_locks, nv_valid} = {16'h0004, 1'b1};
    hold(1);
    nv_valid = 1'b0;
    rchk(8'h0C, 32'h4);
    pot_level = 12'h700;
    hold(4);
    rchk(8'h5A, 32'h900);
    reset = 1'b1;
    hold(3);
    reset = 1'b0;
    rchk(8'h4C, 32'h0);
    rchk(8'h0C, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
